// [inc/sbt_pkg.sv]
// Shared constants and types for the standby command and power-down timer
package sbt_pkg;
  // Command opcodes that mean the same standby request
  localparam logic [7:0] OPC_STANDBY_A = 8'hE2;
  localparam logic [7:0] OPC_STANDBY_B = 8'h96;
  // Status bit positions
  localparam int ST_BSY_BIT = 7;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_DF_BIT  = 5;
  localparam int ST_DSC_BIT = 4;
  localparam int ST_ERR_BIT = 0;
  // Error bit position for an aborted command
  localparam int ER_ABT_BIT = 2;
  // Reset values of status and error
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [7:0] ERROR_RESET  = 8'h00;
  // Clock and tick timing
  localparam longint CLK_HZ       = 20_000_000;
  localparam int     TICK_SEC     = 5;
  localparam longint TICK_CYCLES  = CLK_HZ * TICK_SEC;
  // Timeout code ranges
  localparam logic [7:0] CODE_OFF      = 8'h00;
  localparam logic [7:0] CODE_SEC_MAX  = 8'hF0;
  localparam logic [7:0] CODE_HALF_MAX = 8'hFB;
  localparam logic [7:0] CODE_21M      = 8'hFC;
  localparam logic [7:0] CODE_8H       = 8'hFD;
  localparam logic [7:0] CODE_21M10    = 8'hFE;
  // Fixed interval times, in seconds and minutes
  localparam int HALF_HOUR_MIN = 30;
  localparam int MIN21_MIN     = 21;
  localparam int HOURS8_SEC    = 8 * 3600;
  localparam int EXTRA10_SEC   = 10;
  localparam int EXTRA15_SEC   = 15;
  // The same times as counts of ticks
  localparam int TICKS_WIDTH   = 13;
  localparam logic [12:0] HALF_HOUR_TICKS = 13'(HALF_HOUR_MIN * 60 / TICK_SEC);
  localparam logic [12:0] MIN21_TICKS     = 13'(MIN21_MIN * 60 / TICK_SEC);
  localparam logic [12:0] HOURS8_TICKS    = 13'(HOURS8_SEC / TICK_SEC);
  localparam logic [12:0] MIN21_10_TICKS  = 13'((MIN21_MIN * 60 + EXTRA10_SEC) / TICK_SEC);
  localparam logic [12:0] MIN21_15_TICKS  = 13'((MIN21_MIN * 60 + EXTRA15_SEC) / TICK_SEC);
  // Power states of the drive
  typedef enum logic [1:0] {
    PWR_IDLE,
    PWR_SPIN_DOWN,
    PWR_STANDBY,
    PWR_SPIN_UP
  } sbt_pwr_t;
  // Command taken from the command-block registers
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] count;
  } sbt_cmd_t;
  // Completion registers returned to the host
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
  } sbt_resp_t;
endpackage : sbt_pkg

// [rtl/sbt_decode.sv]
// Decoder from timeout code to interval in five-second ticks
`timescale 1ns/1ns
module sbt_decode (
  input  wire logic [7:0]  i_code,
  output logic      [12:0] o_ticks
);
  import sbt_pkg::*;

  // Range lookup of the code
  always_comb begin
    if (i_code == CODE_OFF) begin
      o_ticks = 13'h0000;
    end else if (i_code <= CODE_SEC_MAX) begin
      o_ticks = {5'h00, i_code};
    end else if (i_code <= CODE_HALF_MAX) begin
      o_ticks = 13'((i_code - CODE_SEC_MAX) * HALF_HOUR_TICKS);
    end else if (i_code == CODE_21M) begin
      o_ticks = MIN21_TICKS;
    end else if (i_code == CODE_8H) begin
      o_ticks = HOURS8_TICKS;
    end else if (i_code == CODE_21M10) begin
      o_ticks = MIN21_10_TICKS;
    end else begin
      o_ticks = MIN21_15_TICKS;
    end
  end
endmodule : sbt_decode

// [rtl/sbt_prescale.sv]
// Prescaler that marks each five-second tick, restartable
`timescale 1ns/1ns
module sbt_prescale #(
  parameter longint TICK_CYCLES = 100_000_000
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_run,
  input  wire logic i_restart,
  output logic      o_tick
);
  import sbt_pkg::*;

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  localparam logic [31:0] LAST = 32'(TICK_CYCLES - 1);

  // Count up while running, wrap at the tick
  always_comb begin
    o_tick   = i_run && !i_restart && (cnt_reg == LAST);
    cnt_next = cnt_reg;
    if (i_restart || !i_run || o_tick) begin
      cnt_next = 32'h0000_0000;
    end else begin
      cnt_next = cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= 32'h0000_0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : sbt_prescale

// [rtl/sbt_standby_ctrl.sv]
// Standby command handling with the automatic power-down timer
// Notes on behaviour
// (RULE_01) Opcodes E2h and 96h both mean the one standby request.
// (RULE_02) An accepted request enters standby at once and loads the timeout.
// (RULE_03) Standby stops the spindle; the host interface stays alive.
// (RULE_04) Spindle already stopped: no spin-down sequence is run.
// (RULE_05) Commands still run in standby; media work waits for full speed.
// (RULE_06) Countdown starts only once the drive is back in idle from standby.
// (RULE_07) Timeout code zero leaves the power-down timer disabled.
// (RULE_08) Any nonzero code enables automatic power-down.
// (RULE_09) Codes map to 5 s, 30 min, 21 min, 8 h and 21 min plus steps.
// (RULE_10) Enabled timer expiring without host access enters standby.
// (RULE_11) Host access before expiry reloads the full interval.
// (RULE_12) The host writes the timeout code before the standby opcode.
// (RULE_13) Completion clears busy and fault; a rejection sets abort and error.
`timescale 1ns/1ns
module sbt_standby_ctrl #(
  parameter longint TICK_CYCLES = sbt_pkg::TICK_CYCLES
) (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_cmd_valid,
  input  wire sbt_pkg::sbt_cmd_t i_cmd,
  input  wire logic              i_host_access,
  input  wire logic              i_media_req,
  input  wire logic              i_spindle_at_speed,
  input  wire logic              i_spindle_stopped,
  output logic                   o_media_grant,
  output logic                   o_motor_on,
  output logic                   o_cmd_done,
  output sbt_pkg::sbt_resp_t     o_resp,
  output sbt_pkg::sbt_pwr_t      o_pwr_state,
  output logic                   o_timer_enabled
);
  import sbt_pkg::*;

  // Pin synchronisers
  logic [1:0] speed_sync_reg;
  logic [1:0] stop_sync_reg;
  logic       at_speed;
  logic       stopped;

  // Control state
  sbt_pwr_t    pwr_reg,    pwr_next;
  logic        motor_reg,  motor_next;
  logic        busy_reg,   busy_next;
  logic        done_reg,   done_next;
  logic        ten_reg,    ten_next;
  logic        armed_reg,  armed_next;
  logic [7:0]  code_reg,   code_next;
  logic [12:0] left_reg,   left_next;
  sbt_resp_t   resp_reg,   resp_next;

  logic        is_standby;
  logic        tick;
  logic        expire;
  logic        restart;
  logic [12:0] load_ticks;
  logic [12:0] new_ticks;
  logic        take;

  assign at_speed = speed_sync_reg[1];
  assign stopped  = stop_sync_reg[1];

  // Two-flop capture of the spindle sense pins
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      speed_sync_reg <= 2'h0;
      stop_sync_reg  <= 2'h0;
    end else begin
      speed_sync_reg <= {speed_sync_reg[0], i_spindle_at_speed};
      stop_sync_reg  <= {stop_sync_reg[0], i_spindle_stopped};
    end
  end

  // Interval of the stored code and of a code arriving now
  sbt_decode u_dec_cur (
    .i_code  (code_reg),
    .o_ticks (load_ticks)
  );
  sbt_decode u_dec_new (
    .i_code  (i_cmd.count),
    .o_ticks (new_ticks)
  );

  // Five-second tick, restarted by any reload of the countdown
  sbt_prescale #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_run     (armed_reg && pwr_reg == PWR_IDLE),
    .i_restart (restart),
    .o_tick    (tick)
  );

  // Request decode and timer events
  assign is_standby = i_cmd_valid && (i_cmd.opcode == OPC_STANDBY_A
                      || i_cmd.opcode == OPC_STANDBY_B);  // [RULE_01]
  assign take    = is_standby && !busy_reg;
  assign restart = i_host_access || take || (pwr_reg == PWR_SPIN_UP && at_speed);
  assign expire  = armed_reg && pwr_reg == PWR_IDLE && tick
                   && left_reg == 13'h0001 && !i_host_access && !take;  // [RULE_10]

  // Media work only at operating speed
  assign o_media_grant = i_media_req && pwr_reg == PWR_IDLE && at_speed;  // [RULE_05]

  // Next-state logic for power state, command and timer
  always_comb begin
    pwr_next   = pwr_reg;
    motor_next = motor_reg;
    busy_next  = busy_reg;
    done_next  = 1'b0;
    ten_next   = ten_reg;
    armed_next = armed_reg;
    code_next  = code_reg;
    left_next  = left_reg;
    resp_next  = resp_reg;
    // Countdown and its reload on host access
    if (armed_reg && pwr_reg == PWR_IDLE) begin
      if (i_host_access) begin
        left_next = load_ticks;  // [RULE_11]
      end else if (tick && left_reg != 13'h0000) begin
        left_next = left_reg - 13'h0001;
      end
    end
    unique case (pwr_reg)
      PWR_IDLE: begin
        if (expire) begin
          motor_next = 1'b0;
          armed_next = 1'b0;
          pwr_next   = stopped ? PWR_STANDBY : PWR_SPIN_DOWN;  // [RULE_10] [RULE_04]
        end
      end
      PWR_SPIN_DOWN: begin
        if (stopped) begin
          pwr_next = PWR_STANDBY;
          if (busy_reg) begin
            busy_next = 1'b0;
            done_next = 1'b1;
            resp_next = '{status: STATUS_RESET, error: ERROR_RESET};  // [RULE_13]
          end
        end
      end
      PWR_STANDBY: begin
        if (i_media_req) begin
          motor_next = 1'b1;  // [RULE_05]
          pwr_next   = PWR_SPIN_UP;
        end
      end
      PWR_SPIN_UP: begin
        if (at_speed) begin
          pwr_next   = PWR_IDLE;
          armed_next = ten_reg;  // [RULE_06]
          left_next  = load_ticks;
        end
      end
    endcase
    // Standby request: immediate entry, timeout loaded alongside
    if (take) begin
      code_next  = i_cmd.count;  // [RULE_02]
      // Zero means timer off; the opposite reading stays open for review
      ten_next   = i_cmd.count != CODE_OFF;  // [RULE_07] [RULE_08]
      left_next  = new_ticks;  // [RULE_09]
      armed_next = 1'b0;
      motor_next = 1'b0;  // [RULE_03]
      if (stopped || pwr_reg == PWR_STANDBY) begin
        pwr_next  = PWR_STANDBY;  // [RULE_04]
        done_next = 1'b1;
        resp_next = '{status: STATUS_RESET, error: ERROR_RESET};  // [RULE_13]
      end else begin
        pwr_next  = PWR_SPIN_DOWN;  // [RULE_02]
        busy_next = 1'b1;
        resp_next.status = STATUS_RESET | (8'h01 << ST_BSY_BIT);
      end
    end else if (is_standby) begin
      // Second request while one is in progress is aborted
      done_next = 1'b1;
      resp_next = '{status: STATUS_RESET | (8'h01 << ST_BSY_BIT) | (8'h01 << ST_ERR_BIT),
                    error:  8'h01 << ER_ABT_BIT};  // [RULE_13]
    end
  end

  // Registers of the control state
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pwr_reg   <= PWR_IDLE;
      motor_reg <= 1'b1;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      ten_reg   <= 1'b0;
      armed_reg <= 1'b0;
      code_reg  <= 8'h00;
      left_reg  <= 13'h0000;
      resp_reg  <= '{status: STATUS_RESET, error: ERROR_RESET};
    end else begin
      pwr_reg   <= pwr_next;
      motor_reg <= motor_next;
      busy_reg  <= busy_next;
      done_reg  <= done_next;
      ten_reg   <= ten_next;
      armed_reg <= armed_next;
      code_reg  <= code_next;
      left_reg  <= left_next;
      resp_reg  <= resp_next;
    end
  end

  // Busy is shown only while a request is in progress
  always_comb begin
    o_resp = resp_reg;
    o_resp.status[ST_BSY_BIT] = busy_reg;
    o_resp.status[ST_DF_BIT]  = 1'b0;
  end

  assign o_motor_on      = motor_reg;
  assign o_cmd_done      = done_reg;
  assign o_pwr_state     = pwr_reg;
  assign o_timer_enabled = ten_reg;

  // Checks on the documented behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  chk_both_opcodes: assert property ( // [RULE_01]
    take |=> pwr_reg inside {PWR_SPIN_DOWN, PWR_STANDBY})
    else $error("standby opcode did not start standby");

  chk_code_loaded: assert property ( // [RULE_02]
    take |=> code_reg == $past(i_cmd.count) && !armed_reg)
    else $error("timeout code not loaded on standby request");

  chk_motor_off: assert property ( // [RULE_03]
    pwr_reg inside {PWR_SPIN_DOWN, PWR_STANDBY} |-> !o_motor_on)
    else $error("spindle motor on in standby");

  chk_skip_spindown: assert property ( // [RULE_04]
    take && stopped |=> pwr_reg == PWR_STANDBY && o_cmd_done)
    else $error("spin-down run with spindle already stopped");

  chk_media_hold: assert property ( // [RULE_05]
    o_media_grant |-> at_speed && pwr_reg == PWR_IDLE)
    else $error("media work granted below speed");

  chk_arm_on_idle: assert property ( // [RULE_06]
    $rose(armed_reg) |-> pwr_reg == PWR_IDLE && $past(pwr_reg) == PWR_SPIN_UP)
    else $error("countdown armed outside return to idle");

  chk_zero_disables: assert property ( // [RULE_07]
    take && i_cmd.count == CODE_OFF
    |=> !o_timer_enabled ##1 (!o_timer_enabled || $past(take)))
    else $error("code zero enabled the timer");

  chk_nonzero_enables: assert property ( // [RULE_08]
    take && i_cmd.count != CODE_OFF |=> o_timer_enabled)
    else $error("nonzero code left timer disabled");

  chk_decode_8h: assert property ( // [RULE_09]
    take && i_cmd.count == CODE_8H |=> left_reg == 13'h1680)
    else $error("eight hour code decoded wrongly");

  chk_auto_standby: assert property ( // [RULE_10]
    expire |=> !o_motor_on && pwr_reg inside {PWR_SPIN_DOWN, PWR_STANDBY})
    else $error("expiry did not enter standby");

  chk_access_reload: assert property ( // [RULE_11]
    armed_reg && pwr_reg == PWR_IDLE && i_host_access && !take
    |=> left_reg == load_ticks && !expire)
    else $error("host access did not reload countdown");

  chk_abort_report: assert property ( // [RULE_13]
    is_standby && busy_reg |=> o_cmd_done && o_resp.error[ER_ABT_BIT]
    && o_resp.status[ST_ERR_BIT] && !o_resp.status[ST_DF_BIT])
    else $error("rejected request not reported as abort");

  chk_done_clean: assert property ( // [RULE_13]
    o_cmd_done && !o_resp.error[ER_ABT_BIT] |-> !o_resp.status[ST_BSY_BIT]
    && !o_resp.status[ST_ERR_BIT])
    else $error("completion left busy or error set");

  chk_standby_answers: assert property ( // [RULE_03]
    pwr_reg == PWR_STANDBY && is_standby |=> o_cmd_done)
    else $error("standby request ignored while spun down");

  chk_standby_wake: assert property ( // [RULE_05]
    pwr_reg == PWR_STANDBY && i_media_req && !take |=> pwr_reg == PWR_SPIN_UP && o_motor_on)
    else $error("media request did not spin the drive up");

  chk_count_in_idle: assert property ( // [RULE_06]
    armed_reg |-> pwr_reg == PWR_IDLE)
    else $error("countdown armed outside idle");

  chk_armed_enabled: assert property ( // [RULE_07]
    armed_reg |-> o_timer_enabled)
    else $error("countdown armed with timer disabled");

  chk_decode_half: assert property ( // [RULE_09]
    take && i_cmd.count == 8'hF1 |=> left_reg == 13'h0168)
    else $error("half hour code decoded wrongly");

  chk_expire_quiet: assert property ( // [RULE_10]
    expire |=> !o_cmd_done)
    else $error("automatic standby raised a completion");

  chk_busy_shown: assert property ( // [RULE_13]
    take && !stopped && pwr_reg != PWR_STANDBY |=> o_resp.status[ST_BSY_BIT] && !o_cmd_done)
    else $error("spin-down request not shown busy");

  chk_spindown_done: assert property ( // [RULE_13]
    pwr_reg == PWR_SPIN_DOWN && busy_reg && stopped |=> o_cmd_done
    && !o_resp.status[ST_BSY_BIT])
    else $error("spin-down completion missing or still busy");
endmodule : sbt_standby_ctrl

// [test/sbt_spindle_model.sv]
// Behavioural spindle for the bench: follows the motor drive after a settable delay
`timescale 1ns/1ns
module sbt_spindle_model (
  input  wire logic       i_clk,
  input  wire logic       i_motor_on,
  input  wire logic [7:0] i_delay,
  output logic            o_at_speed,
  output logic            o_stopped
);
  logic       target;
  logic [7:0] cnt;

  initial begin
    target     = 1'b1;
    cnt        = 8'h00;
    o_at_speed = 1'b1;
    o_stopped  = 1'b0;
  end

  // Both pins low while the platter is changing speed
  always @(negedge i_clk) begin
    if (i_motor_on !== target) begin
      target     = i_motor_on;
      cnt        = i_delay;
      o_at_speed = 1'b0;
      o_stopped  = 1'b0;
    end else if (cnt != 8'h00) begin
      cnt = cnt - 8'h01;
    end else begin
      o_at_speed = target;
      o_stopped  = !target;
    end
  end
endmodule : sbt_spindle_model

// [test/sbt_standby_ctrl_tb.sv]
// Self-checking bench for the standby command and power-down timer
`timescale 1ns/1ns
module sbt_standby_ctrl_tb;
  import sbt_pkg::*;
  localparam longint T = 8;
  logic clk, rstn, cv, acc, req, at_spd, stp, grant, motor, done, ten;
  sbt_cmd_t  cmd;
  sbt_resp_t resp;
  sbt_pwr_t  pwr;
  logic [7:0]  dly;
  logic [31:0] rs;
  logic [7:0]  codes [8];
  int num_errors, n_checks, cyc;

  sbt_standby_ctrl #(.TICK_CYCLES(T)) dut (.i_clk(clk), .i_resetn(rstn), .i_cmd_valid(cv),
    .i_cmd(cmd), .i_host_access(acc), .i_media_req(req), .i_spindle_at_speed(at_spd),
    .i_spindle_stopped(stp), .o_media_grant(grant), .o_motor_on(motor), .o_cmd_done(done),
    .o_resp(resp), .o_pwr_state(pwr), .o_timer_enabled(ten));
  sbt_spindle_model far (.i_clk(clk), .i_motor_on(motor), .i_delay(dly),
    .o_at_speed(at_spd), .o_stopped(stp));

  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 100000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  // Interval in five-second ticks for a timeout code
  function automatic int exp_ticks(input logic [7:0] c);
    if (c <= 8'hF0) return int'(c);
    if (c <= 8'hFB) return (int'(c) - 240) * 360;
    case (c)
      8'hFC:   return (21 * 60) / 5;
      8'hFD:   return (8 * 3600) / 5;
      8'hFE:   return (21 * 60 + 10) / 5;
      default: return (21 * 60 + 15) / 5;
    endcase
  endfunction : exp_ticks

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %0t %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Count and opcode written together, valid for one rising edge
  task automatic issue(input logic [7:0] op, input logic [7:0] code);
    cmd = '{opcode: op, count: code};
    cv  = 1'b1;
    @(negedge clk);
    cv  = 1'b0;
  endtask : issue

  // Negedges until the completion pulse shows, zero if it shows already
  task automatic wait_done(input int mx, output int n);
    n = 0;
    while (done !== 1'b1 && n < mx) begin
      @(negedge clk);
      n = n + 1;
    end
  endtask : wait_done

  task automatic standby(input logic [7:0] op, input logic [7:0] code);
    logic was_sb;
    int   n;
    was_sb = (pwr === PWR_STANDBY);
    issue(op, code);
    wait_done(400, n);
    if (was_sb) check(16'(n), 16'h0000, "done latency in standby");
    check(resp, 16'h5000, "completion regs");
    check(16'(pwr), 16'(PWR_STANDBY), "state after standby");
    check(16'(motor), 16'h0000, "motor after standby");
  endtask : standby

  task automatic to_idle();
    int n;
    req = 1'b1;
    @(negedge clk);
    check(16'(grant), 16'h0000, "grant while spinning up");
    n = 0;
    while (grant !== 1'b1 && n < 400) begin
      @(negedge clk);
      n = n + 1;
    end
    check(16'(pwr), 16'(PWR_IDLE), "idle at grant");
    check(16'(grant & at_spd), 16'h0001, "grant at speed");
    req = 1'b0;
  endtask : to_idle

  task automatic run_timer(input logic [7:0] op, input logic [7:0] code, input int acc_at);
    int n;
    int e;
    standby(op, code);
    check(16'(ten), 16'(code != 8'h00), "timer enable");
    repeat (30) @(negedge clk);
    to_idle();
    if (code == 8'h00) begin
      repeat (200) @(negedge clk);
      check(16'(motor), 16'h0001, "motor kept on");
    end else begin
      // Expiry counted from arming, or from the edge that takes the access
      e = exp_ticks(code) * int'(T) + ((acc_at > 0) ? acc_at + 1 : 0);
      n = 0;
      while (motor === 1'b1 && n < e + 40) begin
        @(negedge clk);
        n = n + 1;
        acc = (n == acc_at);
      end
      check(16'(n), 16'(e), "expiry time");
      check(16'(done), 16'h0000, "no done on auto standby");
      n = 0;
      while (pwr !== PWR_STANDBY && n < 400) begin
        @(negedge clk);
        n = n + 1;
      end
      check(16'(pwr), 16'(PWR_STANDBY), "auto standby state");
    end
  endtask : run_timer

  initial begin
    int n;
    clk = 1'b0; rstn = 1'b0; cv = 1'b0; acc = 1'b0; req = 1'b0;
    cmd = '0; dly = 8'h04; rs = 32'h33CFEFEC;
    codes = '{8'h01, 8'h02, 8'hF0, 8'hF1, 8'hFC, 8'hFE, 8'hFF, 8'hFD};
    num_errors = 0; n_checks = 0; cyc = 0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check(resp, {STATUS_RESET, ERROR_RESET}, "reset regs");
    // Unrelated opcode must not complete
    issue(8'hE8, 8'h01);
    repeat (6) begin
      @(negedge clk);
      check(16'(done), 16'h0000, "foreign opcode");
    end
    // Second request during a slow spin-down is aborted
    dly = 8'h14;
    issue(OPC_STANDBY_A, 8'h01);
    check(16'(motor), 16'h0000, "spin-down starts at once");
    @(negedge clk);
    issue(OPC_STANDBY_B, 8'h01);
    wait_done(4, n);
    check(16'(n), 16'h0000, "abort latency");
    check({resp.status[ST_ERR_BIT], resp.error}, 16'h0104, "abort regs");
    @(negedge clk);
    wait_done(400, n);
    check(resp, 16'h5000, "original completes");
    // Disabled timer, then fixed and random codes
    run_timer(OPC_STANDBY_B, 8'h00, 0);
    for (int i = 0; i < 8; i++) begin
      run_timer(i[0] ? OPC_STANDBY_B : OPC_STANDBY_A, codes[i], (i == 1) ? 6 : 0);
    end
    repeat (3) begin
      dly = 8'(2 + rnd() % 16);
      run_timer(OPC_STANDBY_A, 8'(1 + rnd() % 240), 0);
    end
    // Reset in mid-run, then a request at the first edge after release
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    check(16'({motor, ten, done}), 16'h0004, "outputs held in reset");
    check(16'(pwr), 16'(PWR_IDLE), "state held in reset");
    rstn = 1'b1;
    standby(OPC_STANDBY_B, 8'h00);
    check(16'(ten), 16'h0000, "timer off after restart");
    report_and_stop();
  end
endmodule : sbt_standby_ctrl_tb
